// *** hw/lfsr_command_status.sv ***
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - At the bulk list head a zero bulk filled flag makes the controller skip bulk work.
// - At the bulk list head a set bulk filled flag starts bulk work and clears the flag.
// - Each descriptor found on the bulk list sets the bulk filled flag again.
// - With no descriptor found and no software set, the bulk flag stays zero and bulk work stops.
// - At the control list head a zero flag skips control work, a one starts it and clears it.
// - Each descriptor found on the control list sets the control filled flag again.
// - With no descriptor found and no software set, the control flag stays zero and work stops.
// - Writing one to the soft reset bit starts a software reset of the controller.
// - Soft reset forces the suspend state and clears operational state but keeps interrupt routing.
// - No host bus access is started while a soft reset is in progress.
// - The soft reset ends within 10 us and the controller then clears the reset bit itself.
// - Soft reset leaves the root hub alone and drives no reset onto downstream ports.
// - The command-status register is write-to-set and reads back normally.
module lfsr_command_status (
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// Register port.
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output var  logic [31:0] reg_rdata,
	// List engine events.
	input  wire logic        bulk_at_head,
	input  wire logic        bulk_td_seen,
	input  wire logic        bulk_list_end,
	input  wire logic        ctrl_at_head,
	input  wire logic        ctrl_td_seen,
	input  wire logic        ctrl_list_end,
	input  wire logic        sched_overrun,
	input  wire logic        interrupt_routing_bit,
	// Controller status.
	output var  logic        host_bus_enable,
	output var  logic        soft_reset_busy,
	output var  logic [1:0]  func_state,
	output var  logic        bulk_active,
	output var  logic        ctrl_active,
	output var  logic        routing_kept
);
	lfsr_list_if bulk_lnk ();
	lfsr_list_if ctrl_lnk ();

	logic        bulk_list_filled_reg;
	logic        bulk_list_filled_next;
	logic        control_list_filled_reg;
	logic        control_list_filled_next;
	logic        controller_soft_reset_reg;
	logic        controller_soft_reset_next;
	logic        own_request_reg;
	logic        own_request_next;
	logic [1:0]  overrun_count_reg;
	logic [1:0]  overrun_count_next;
	logic [7:0]  reset_count_reg;
	logic [7:0]  reset_count_next;
	lfsr_pkg::lfsr_func_e state_reg;
	lfsr_pkg::lfsr_func_e state_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        bus_en_reg;
	logic        routing_reg;
	logic        cmd_write;
	logic        reset_done;

	assign cmd_write  = reg_write && (reg_addr == lfsr_pkg::ADDR_COMMAND_STATUS);
	assign reset_done = controller_soft_reset_reg && (reset_count_reg == 8'h00);

	// One walker per nonperiodic list; a soft reset aborts both passes.
	assign bulk_lnk.filled = bulk_list_filled_reg;
	assign ctrl_lnk.filled = control_list_filled_reg;
	assign bulk_lnk.abort  = controller_soft_reset_reg;
	assign ctrl_lnk.abort  = controller_soft_reset_reg;

	lfsr_list_walker u_bulk (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.at_head  (bulk_at_head),
		.td_seen  (bulk_td_seen),
		.list_end (bulk_list_end),
		.lnk      (bulk_lnk)
	);

	lfsr_list_walker u_ctrl (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.at_head  (ctrl_at_head),
		.td_seen  (ctrl_td_seen),
		.list_end (ctrl_list_end),
		.lnk      (ctrl_lnk)
	);

	// Next values of the command-status bits; software sets win over hardware clears, except a soft reset write while a soft reset runs.
	always_comb begin
		bulk_list_filled_next      = bulk_list_filled_reg;
		control_list_filled_next   = control_list_filled_reg;
		controller_soft_reset_next = controller_soft_reset_reg;
		own_request_next           = own_request_reg;
		overrun_count_next         = overrun_count_reg;
		reset_count_next           = reset_count_reg;
		state_next                 = state_reg;
		if (bulk_lnk.start) begin
			bulk_list_filled_next = 1'b0;
		end
		if (bulk_lnk.td_found) begin
			bulk_list_filled_next = 1'b1;
		end
		if (ctrl_lnk.start) begin
			control_list_filled_next = 1'b0;
		end
		if (ctrl_lnk.td_found) begin
			control_list_filled_next = 1'b1;
		end
		if (sched_overrun) begin
			overrun_count_next = overrun_count_reg + 2'b01;
		end
		if (controller_soft_reset_reg) begin
			reset_count_next = reset_count_reg - 8'h01;
			bulk_list_filled_next    = 1'b0;
			control_list_filled_next = 1'b0;
			own_request_next         = 1'b0;
			overrun_count_next       = 2'b00;
			state_next               = lfsr_pkg::LFSR_FUNC_SUSPEND;
		end
		if (reset_done) begin
			controller_soft_reset_next = 1'b0;
		end
		if (cmd_write) begin
			// Ones set, zeros leave bits alone.
			if (reg_wdata[lfsr_pkg::BIT_BULK_FILLED]) begin
				bulk_list_filled_next = 1'b1;
			end
			if (reg_wdata[lfsr_pkg::BIT_CTRL_FILLED]) begin
				control_list_filled_next = 1'b1;
			end
			if (reg_wdata[lfsr_pkg::BIT_OWN_REQUEST]) begin
				own_request_next = 1'b1;
			end
			if (reg_wdata[lfsr_pkg::BIT_SOFT_RESET] && !controller_soft_reset_reg) begin
				controller_soft_reset_next = 1'b1;
				reset_count_next           = lfsr_pkg::SOFT_RESET_RUN_CNT;
			end
		end
	end

	// Read data for the cycle after a read strobe.
	always_comb begin
		rdata_next = lfsr_pkg::READ_ZERO;
		if (reg_read && reg_addr == lfsr_pkg::ADDR_COMMAND_STATUS) begin
			rdata_next[lfsr_pkg::BIT_SOFT_RESET]  = controller_soft_reset_reg;
			rdata_next[lfsr_pkg::BIT_CTRL_FILLED] = control_list_filled_reg;
			rdata_next[lfsr_pkg::BIT_BULK_FILLED] = bulk_list_filled_reg;
			rdata_next[lfsr_pkg::BIT_OWN_REQUEST] = own_request_reg;
			rdata_next[lfsr_pkg::SOC_LSB +: 2]    = overrun_count_reg;
		end else if (reg_read && reg_addr == lfsr_pkg::ADDR_LIST_STATUS) begin
			rdata_next[lfsr_pkg::BIT_SUSPENDED]   = (state_reg == lfsr_pkg::LFSR_FUNC_SUSPEND);
			rdata_next[lfsr_pkg::BIT_BULK_ACTIVE] = bulk_lnk.active;
			rdata_next[lfsr_pkg::BIT_CTRL_ACTIVE] = ctrl_lnk.active;
			rdata_next[lfsr_pkg::BIT_BUS_BLOCKED] = controller_soft_reset_reg;
		end
	end

	// Registers all state; the interrupt routing bit is cleared by reset_n but is outside the soft reset path.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			bulk_list_filled_reg      <= lfsr_pkg::CMD_RESET_VALUE[lfsr_pkg::BIT_BULK_FILLED];
			control_list_filled_reg   <= lfsr_pkg::CMD_RESET_VALUE[lfsr_pkg::BIT_CTRL_FILLED];
			controller_soft_reset_reg <= lfsr_pkg::CMD_RESET_VALUE[lfsr_pkg::BIT_SOFT_RESET];
			own_request_reg           <= lfsr_pkg::CMD_RESET_VALUE[lfsr_pkg::BIT_OWN_REQUEST];
			overrun_count_reg         <= 2'b00;
			reset_count_reg           <= 8'h00;
			state_reg                 <= lfsr_pkg::LFSR_FUNC_RESET;
			rdata_reg                 <= lfsr_pkg::READ_ZERO;
			bus_en_reg                <= 1'b0;
			routing_reg               <= 1'b0;
		end else begin
			bulk_list_filled_reg      <= bulk_list_filled_next;
			control_list_filled_reg   <= control_list_filled_next;
			controller_soft_reset_reg <= controller_soft_reset_next;
			own_request_reg           <= own_request_next;
			overrun_count_reg         <= overrun_count_next;
			reset_count_reg           <= reset_count_next;
			state_reg                 <= state_next;
			rdata_reg                 <= rdata_next;
			bus_en_reg                <= !controller_soft_reset_next;
			routing_reg               <= interrupt_routing_bit;
		end
	end

	// Outputs straight from flip-flops; no root hub or port reset is driven.
	assign reg_rdata       = rdata_reg;
	assign host_bus_enable = bus_en_reg;
	assign soft_reset_busy = controller_soft_reset_reg;
	assign func_state      = state_reg;
	assign bulk_active     = bulk_lnk.active;
	assign ctrl_active     = ctrl_lnk.active;
	assign routing_kept    = routing_reg;

	// Assertions.
	a_bulk_skip_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
		bulk_at_head && !bulk_list_filled_reg && !bulk_lnk.active |=> !bulk_lnk.active)
		else $error("Bulk pass started with empty flag.");
	a_bulk_start_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
		bulk_lnk.start && !cmd_write |=> !bulk_list_filled_reg && bulk_lnk.active)
		else $error("Bulk start did not clear flag.");
	a_bulk_td_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
		bulk_lnk.td_found |=> bulk_list_filled_reg)
		else $error("Bulk descriptor did not set flag.");
	a_bulk_stays_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!bulk_list_filled_reg && !bulk_lnk.td_found && !cmd_write |=> !bulk_list_filled_reg)
		else $error("Bulk flag rose without cause.");
	a_ctrl_start_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
		ctrl_lnk.start && !cmd_write |=> !control_list_filled_reg && ctrl_lnk.active)
		else $error("Control start did not clear flag.");
	a_ctrl_td_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
		ctrl_lnk.td_found |=> control_list_filled_reg)
		else $error("Control descriptor did not set flag.");
	a_ctrl_stays_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!control_list_filled_reg && !ctrl_lnk.td_found && !cmd_write |=> !control_list_filled_reg)
		else $error("Control flag rose without cause.");
	a_reset_write_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
		cmd_write && reg_wdata[lfsr_pkg::BIT_SOFT_RESET] |=> controller_soft_reset_reg)
		else $error("Reset write did not start reset.");
	a_reset_suspend: assert property (@(posedge sys_clk) disable iff (!reset_n)
		controller_soft_reset_reg |=> state_reg == lfsr_pkg::LFSR_FUNC_SUSPEND)
		else $error("Soft reset did not enter suspend.");
	a_reset_no_bus: assert property (@(posedge sys_clk) disable iff (!reset_n)
		controller_soft_reset_reg |-> !host_bus_enable)
		else $error("Host bus enabled during soft reset.");
	a_reset_bounded: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(controller_soft_reset_reg) |-> ##[1:200] !controller_soft_reset_reg)
		else $error("Soft reset exceeded its time.");
	a_write_keeps: assert property (@(posedge sys_clk) disable iff (!reset_n)
		cmd_write && bulk_list_filled_reg && !bulk_lnk.start && !controller_soft_reset_reg
		|=> bulk_list_filled_reg)
		else $error("Write of zero cleared bulk flag.");
	a_reset_readback: assert property (@(posedge sys_clk) disable iff (!reset_n)
		reg_read && reg_addr == lfsr_pkg::ADDR_COMMAND_STATUS && controller_soft_reset_reg
		|=> reg_rdata[lfsr_pkg::BIT_SOFT_RESET])
		else $error("Reset bit read back as zero.");

	c_bulk_pass: cover property (@(posedge sys_clk) disable iff (!reset_n)
		bulk_lnk.start ##[1:20] bulk_lnk.pass_done);
	c_ctrl_refill: cover property (@(posedge sys_clk) disable iff (!reset_n)
		ctrl_lnk.start ##[1:20] ctrl_lnk.td_found);
	c_soft_reset: cover property (@(posedge sys_clk) disable iff (!reset_n)
		$fell(controller_soft_reset_reg));

endmodule : lfsr_command_status
`default_nettype wire

// *** pkg/lfsr_pkg.sv ***
package lfsr_pkg;

	// Register map. The command-status offset is a local choice.
	localparam logic [7:0] ADDR_COMMAND_STATUS = 8'h08;
	localparam logic [7:0] ADDR_LIST_STATUS    = 8'h0C;

	// Command-status field positions.
	localparam int BIT_SOFT_RESET   = 0;
	localparam int BIT_CTRL_FILLED  = 1;
	localparam int BIT_BULK_FILLED  = 2;
	localparam int BIT_OWN_REQUEST  = 3;
	localparam int SOC_LSB          = 16;

	// List-status field positions.
	localparam int BIT_SUSPENDED    = 0;
	localparam int BIT_BULK_ACTIVE  = 1;
	localparam int BIT_CTRL_ACTIVE  = 2;
	localparam int BIT_BUS_BLOCKED  = 3;

	// Reset values.
	localparam logic [31:0] CMD_RESET_VALUE = 32'h0000_0000;
	localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

	// Timing: the soft reset must end within 10 us at a 50 ns clock.
	localparam int CLK_PERIOD_NS      = 50;
	localparam int SOFT_RESET_MAX_US  = 10;
	localparam int SOFT_RESET_CYCLES  = (SOFT_RESET_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int SOFT_RESET_RUN     = SOFT_RESET_CYCLES - 8;
	localparam logic [7:0] SOFT_RESET_RUN_CNT = 8'(SOFT_RESET_RUN);

	// Functional states of the controller.
	typedef enum logic [1:0] {
		LFSR_FUNC_RESET,
		LFSR_FUNC_RESUME,
		LFSR_FUNC_OPERATIONAL,
		LFSR_FUNC_SUSPEND
	} lfsr_func_e;

endpackage : lfsr_pkg

// *** pkg/lfsr_list_if.sv ***
`timescale 1ns/1ns
`default_nettype none
// Signals between the register bank and one list walker.
interface lfsr_list_if;
	logic filled;
	logic start;
	logic td_found;
	logic pass_done;
	logic active;
	logic abort;
	modport bank (output filled, output abort, input start, input td_found, input pass_done,
		input active);
	modport walker (input filled, input abort, output start, output td_found,
		output pass_done, output active);
endinterface : lfsr_list_if
`default_nettype wire

// *** hw/lfsr_list_walker.sv ***
`timescale 1ns/1ns
`default_nettype none
// Tracks one nonperiodic list pass from the list head to its end.
module lfsr_list_walker (
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// Scheduler events from the list engine.
	input  wire logic        at_head,
	input  wire logic        td_seen,
	input  wire logic        list_end,
	// Link to the register bank.
	lfsr_list_if.walker      lnk
);
	logic active_reg;
	logic active_next;

	// Starts a pass only when the filled flag is set; abort ends it.
	always_comb begin
		active_next = active_reg;
		if (lnk.abort) begin
			active_next = 1'b0;
		end else if (at_head && !active_reg && lnk.filled) begin
			active_next = 1'b1;
		end else if (active_reg && list_end) begin
			active_next = 1'b0;
		end
	end

	// Registers the pass state.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			active_reg <= 1'b0;
		end else begin
			active_reg <= active_next;
		end
	end

	// Events for the bank; a zero flag skips the list entirely.
	assign lnk.start     = at_head && !active_reg && lnk.filled && !lnk.abort;
	assign lnk.td_found  = active_reg && td_seen && !lnk.abort;
	assign lnk.pass_done = active_reg && list_end && !lnk.abort;
	assign lnk.active    = active_reg;

endmodule : lfsr_list_walker
`default_nettype wire

// *** verification/lfsr_list_engine_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Behavioural list engine: walks one nonperiodic list on request and reports each event as a
// one-cycle pulse, except back-to-back descriptors: a gap of zero holds td_seen high across them, larger gaps give a slow walk.
module lfsr_list_engine_model (
	// Clock.
	input  wire logic       sys_clk,
	// Request from the bench.
	input  wire logic       run,
	input  wire logic [3:0] td_count,
	input  wire logic [3:0] gap,
	// Events towards the controller.
	output var  logic       at_head,
	output var  logic       td_seen,
	output var  logic       list_end
);
	int n;
	int g;

	// Idle with all events low until a request arrives.
	initial begin
		at_head = 1'b0;
		td_seen = 1'b0;
		list_end = 1'b0;
	end

	// One pass: head, the asked number of descriptors, then the end of the list.
	always begin
		@(posedge sys_clk);
		if (run === 1'b1) begin
			n = int'(td_count);
			g = int'(gap);
			at_head <= 1'b1;
			@(posedge sys_clk);
			at_head <= 1'b0;
			// With no gap the strobe stays high between descriptors instead of dropping and
			// rising again in the same time step.
			for (int i = 0; i < n; i++) begin
				repeat (g) @(posedge sys_clk);
				td_seen <= 1'b1;
				@(posedge sys_clk);
				if (g != 0 || i == n - 1) begin
					td_seen <= 1'b0;
				end
			end
			list_end <= 1'b1;
			@(posedge sys_clk);
			list_end <= 1'b0;
		end
	end
endmodule : lfsr_list_engine_model
`default_nettype wire

// *** verification/tb_list_filled_and_soft_reset.sv ***
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the command-status bank with two list engine models.
module tb_list_filled_and_soft_reset;
	logic        sys_clk, reset_n, reg_write, reg_read, sched_overrun, interrupt_routing_bit;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd;
	logic [1:0]  run;
	wire logic [1:0] at_head, td_seen, list_end;
	logic [3:0]  td_count, gap;
	logic        host_bus_enable, soft_reset_busy, bulk_active, ctrl_active, routing_kept;
	logic [1:0]  func_state;
	int          bad_count, compares, cnt;

	lfsr_command_status lfsr_command_status_i (.sys_clk(sys_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .bulk_at_head(at_head[0]),
		.bulk_td_seen(td_seen[0]), .bulk_list_end(list_end[0]), .ctrl_at_head(at_head[1]),
		.ctrl_td_seen(td_seen[1]), .ctrl_list_end(list_end[1]),
		.sched_overrun(sched_overrun), .interrupt_routing_bit(interrupt_routing_bit),
		.host_bus_enable(host_bus_enable), .soft_reset_busy(soft_reset_busy),
		.func_state(func_state), .bulk_active(bulk_active), .ctrl_active(ctrl_active),
		.routing_kept(routing_kept));

	// Index 0 walks the bulk list, index 1 the control list.
	for (genvar k = 0; k < 2; k++) begin : g_eng
		lfsr_list_engine_model lfsr_list_engine_model_i (.sys_clk(sys_clk), .run(run[k]),
			.td_count(td_count), .gap(gap), .at_head(at_head[k]), .td_seen(td_seen[k]),
			.list_end(list_end[k]));
	end

	// Clock of 50 ns period.
	always #25 sys_clk = ~sys_clk;

	// Word comparison with report on mismatch.
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	// Single status bit comparison.
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask : chk_bit

	// One-cycle register write.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask : wr

	// One-cycle register read; data are taken in the cycle after the strobe.
	task automatic rdr(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask : rdr

	// Runs one list pass and checks whether the walker became active.
	task automatic pass(input int w, input logic [3:0] n, input logic [3:0] gp, input logic act);
		@(posedge sys_clk);
		run[w] <= 1'b1;
		td_count <= n;
		gap <= gp;
		@(posedge sys_clk);
		run[w] <= 1'b0;
		@(posedge sys_clk);
		#1 chk_bit((w == 1) ? ctrl_active : bulk_active, act);
		cnt = 0;
		while (list_end[w] !== 1'b1 && cnt < 100) begin
			@(posedge sys_clk);
			cnt++;
		end
		repeat (2) @(posedge sys_clk);
	endtask : pass

	// Prints the counts and the verdict, then stops.
	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out

	// Watchdog against a hung run.
	initial begin
		#1000000;
		bad_count++;
		close_out();
	end

	// Main sequence.
	initial begin
		sys_clk = 1'b0;
		reset_n = 1'b0;
		{reg_write, reg_read, sched_overrun, interrupt_routing_bit} = 4'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		{run, td_count, gap} = 10'h000;
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		interrupt_routing_bit <= 1'b1;
		rdr(lfsr_pkg::ADDR_COMMAND_STATUS, rd);
		chk_word(rd, lfsr_pkg::CMD_RESET_VALUE);
		chk_bit(host_bus_enable, 1'b1);
		// Write-to-set: zeros keep bits, unmapped places read zero.
		wr(lfsr_pkg::ADDR_COMMAND_STATUS, 32'h0000_0004);
		wr(lfsr_pkg::ADDR_COMMAND_STATUS, 32'h0000_0002);
		wr(lfsr_pkg::ADDR_COMMAND_STATUS, 32'h0000_0000);
		wr(8'h40, 32'h0000_0001);
		rdr(lfsr_pkg::ADDR_COMMAND_STATUS, rd);
		chk_word(rd, 32'h0000_0006);
		rdr(8'h40, rd);
		chk_word(rd, 32'h0000_0000);
		chk_bit(soft_reset_busy, 1'b0);
		// Each list: a pass with a descriptor keeps the flag, an empty one clears it.
		for (int w = 0; w < 2; w++) begin
			pass(w, 4'h1, (w == 0) ? 4'h0 : 4'h3, 1'b1);
			rdr(lfsr_pkg::ADDR_COMMAND_STATUS, rd);
			chk_bit(rd[lfsr_pkg::BIT_BULK_FILLED - w], 1'b1);
			pass(w, 4'h0, 4'h0, 1'b1);
			rdr(lfsr_pkg::ADDR_COMMAND_STATUS, rd);
			chk_bit(rd[lfsr_pkg::BIT_BULK_FILLED - w], 1'b0);
			pass(w, 4'h2, 4'h0, 1'b0);
		end
		// Overrun count wraps after four, the fifth leaves one.
		repeat (5) begin
			@(posedge sys_clk);
			sched_overrun <= 1'b1;
			@(posedge sys_clk);
			sched_overrun <= 1'b0;
		end
		wr(lfsr_pkg::ADDR_COMMAND_STATUS, 32'h0000_000E);
		rdr(lfsr_pkg::ADDR_COMMAND_STATUS, rd);
		chk_word(rd, 32'h0001_000E);
		// Soft reset: busy, suspended, bus quiet, then self-clearing within 10 us.
		wr(lfsr_pkg::ADDR_COMMAND_STATUS, 32'h0000_0001);
		#1 chk_bit(soft_reset_busy, 1'b1);
		chk_bit(host_bus_enable, 1'b0);
		rdr(lfsr_pkg::ADDR_COMMAND_STATUS, rd);
		chk_word(rd, 32'h0000_0001);
		// List status during the reset: suspended and bus blocked, no pass active.
		rdr(lfsr_pkg::ADDR_LIST_STATUS, rd);
		chk_word(rd, 32'h0000_0009);
		chk_word({30'h0000_0000, func_state}, {30'h0000_0000, lfsr_pkg::LFSR_FUNC_SUSPEND});
		cnt = 4;
		while (soft_reset_busy === 1'b1 && cnt < 260) begin
			@(posedge sys_clk);
			#1 cnt++;
		end
		chk_bit(cnt <= lfsr_pkg::SOFT_RESET_CYCLES, 1'b1);
		chk_bit(routing_kept, 1'b1);
		rdr(lfsr_pkg::ADDR_COMMAND_STATUS, rd);
		chk_word(rd, 32'h0000_0000);
		close_out();
	end
endmodule : tb_list_filled_and_soft_reset
`default_nettype wire
